// File: inc/ldp_pkg.sv
`default_nettype none

package ldp_pkg;

  //==========================================================
  // Clock and generator timing
  //==========================================================
  localparam int unsigned CLK_HZ       = 200_000_000;
  // Generator frequency numerator, Hz times kOhm
  localparam int unsigned FREQ_NUMER   = 20_000;
  localparam int unsigned FREQ_MIN_HZ  = 100;
  localparam int unsigned FREQ_MAX_HZ  = 2_000;
  localparam int unsigned CYC_PER_KOHM = CLK_HZ / FREQ_NUMER;
  // Duty percent factors, held in tenths
  localparam int unsigned DUTY_NUM_X10 = 1;
  localparam int unsigned DUTY_DEN_X10 = 36;

  //==========================================================
  // Widths
  //==========================================================
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned FREQ_W = 8;
  localparam int unsigned DUTY_W = 12;
  localparam int unsigned PER_W  = 21;
  localparam int unsigned PD_W   = 33;

  //==========================================================
  // Setting limits and reset values
  //==========================================================
  localparam logic [FREQ_W-1:0] FREQ_K_MIN = FREQ_W'(FREQ_NUMER / FREQ_MAX_HZ);
  localparam logic [FREQ_W-1:0] FREQ_K_MAX = FREQ_W'(FREQ_NUMER / FREQ_MIN_HZ);
  localparam logic [DUTY_W-1:0] DUTY_SCALE = DUTY_W'(100 * DUTY_DEN_X10 / DUTY_NUM_X10);
  localparam logic [DUTY_W-1:0] DUTY_K_MAX = 12'h0E10;
  localparam logic [FREQ_W-1:0] FREQ_RST   = 8'h64;
  localparam logic [DUTY_W-1:0] DUTY_RST   = 12'h0708;
  localparam logic              EXT_SYNC_RST = 1'b0;
  localparam logic              SEL_SYNC_RST = 1'b0;

  //==========================================================
  // Register map
  //==========================================================
  localparam logic [ADDR_W-1:0] OFS_DUTY   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FREQ   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h0C;
  localparam int unsigned ST_EXT     = 0;
  localparam int unsigned ST_SEL     = 1;
  localparam int unsigned ST_GEN_ON  = 2;
  localparam int unsigned ST_GEN_OUT = 3;
  localparam int unsigned ST_GATE    = 4;

  //==========================================================
  // Carriers
  //==========================================================
  typedef struct packed {
    logic [FREQ_W-1:0] freq;
    logic [DUTY_W-1:0] duty;
  } ldp_cfg_type;

  typedef struct packed {
    logic             out;
    logic [PER_W-1:0] per;
  } ldp_gen_type;

endpackage

`default_nettype wire

// File: logic/ldp_dimming_top.sv
//==============================================================
// Dimming control
//==============================================================
// Notes on behaviour
// - External dimming input high enables switching and turns the series switch on.
// - External dimming input low stops switching and turns the series switch off.
// - Gate drive output is a buffered copy following every edge of the input while select is high.
// - Average LED current is full current times the applied dimming duty.
// - Select high disables the internal generator and gives full current.
// - Select low enables the generator, which gates switching and gate drive.
// - Generator duty percent is 0.1 times duty setting in kilohms over 3.6.
// - Generator frequency is settable from 100 Hz to 2 kHz.
// - Generator frequency in hertz is 2e4 over frequency setting in kilohms.
// - Unconnected select input reads low, so the generator dims by default.
`default_nettype none

module ldp_dimming_top
  import ldp_pkg::*;
#(
  parameter int unsigned P_CYC_PER_KOHM = CYC_PER_KOHM
)
(
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output var  logic [31:0]       PRDATA,
  output var  logic              PREADY,
  output var  logic              PSLVERR,
  // Dimming pins, asynchronous to MCLK
  input  wire logic              EXT_DIM_IN,
  input  wire logic              INT_DIM_SELECT_N,
  // Converter switching and series switch
  output var  logic              SWITCH_ENABLE,
  output var  logic              PMOS_GATE_DRIVE_OUT
);

  //============================================================
  // State and signals
  //============================================================
  typedef struct packed {
    logic [FREQ_W-1:0] freq;
    logic [DUTY_W-1:0] duty;
    logic [31:0]       rdata;
    logic              err;
    logic              gate;
  } ldp_top_state_type;

  ldp_top_state_type st_q;
  ldp_top_state_type st_d;
  logic              ext_s;
  logic              sel_s;
  logic              gen_en;
  ldp_cfg_type       cfg;
  ldp_gen_type       gen;
  logic              setup_ph;
  logic              access_ph;
  logic              mapped;
  logic [31:0]       rd_val;
  logic [31:0]       wr_duty;
  logic [31:0]       wr_freq;

  //============================================================
  // Helpers
  //============================================================
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Out-of-range frequency writes saturate rather than fault
  function automatic logic [FREQ_W-1:0] clamp_freq(input logic [31:0] v);
    logic [FREQ_W-1:0] res;
    if (v < 32'(FREQ_K_MIN))
    begin
      res = FREQ_K_MIN;
    end
    else if (v > 32'(FREQ_K_MAX))
    begin
      res = FREQ_K_MAX;
    end
    else
    begin
      res = v[FREQ_W-1:0];
    end
    return res;
  endfunction

  function automatic logic [DUTY_W-1:0] clamp_duty(input logic [31:0] v);
    logic [DUTY_W-1:0] res;
    if (v > 32'(DUTY_K_MAX))
    begin
      res = DUTY_K_MAX;
    end
    else
    begin
      res = v[DUTY_W-1:0];
    end
    return res;
  endfunction

  //============================================================
  // Pin synchronisers
  //============================================================
  ldp_sync #(
    .RST_VAL (EXT_SYNC_RST)
  ) u_ext_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (EXT_DIM_IN),
    .q     (ext_s)
  );

  // Reset low matches the pin's pull-down: generator on until sampled
  ldp_sync #(
    .RST_VAL (SEL_SYNC_RST)
  ) u_sel_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (INT_DIM_SELECT_N),
    .q     (sel_s)
  );

  //============================================================
  // Internal generator
  //============================================================
  assign gen_en   = !sel_s;
  assign cfg.freq = st_q.freq;
  assign cfg.duty = st_q.duty;

  ldp_pwm_gen #(
    .P_CYC_PER_KOHM (P_CYC_PER_KOHM)
  ) u_gen (
    .clk   (MCLK),
    .rst_n (RST_N),
    .en    (gen_en),
    .cfg   (cfg),
    .gen   (gen)
  );

  //============================================================
  // Register decode
  //============================================================
  always_comb
  begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (PADDR)
      OFS_DUTY:
      begin
        rd_val = 32'(st_q.duty);
      end
      OFS_FREQ:
      begin
        rd_val = 32'(st_q.freq);
      end
      OFS_STATUS:
      begin
        rd_val[ST_EXT]     = ext_s;
        rd_val[ST_SEL]     = sel_s;
        rd_val[ST_GEN_ON]  = gen_en;
        rd_val[ST_GEN_OUT] = gen.out;
        rd_val[ST_GATE]    = st_q.gate;
      end
      OFS_PERIOD:
      begin
        rd_val = 32'(gen.per);
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  assign setup_ph  = PSEL && !PENABLE;
  assign access_ph = PSEL && PENABLE;
  assign wr_duty   = merge_lanes(32'(st_q.duty), PWDATA, PSTRB);
  assign wr_freq   = merge_lanes(32'(st_q.freq), PWDATA, PSTRB);

  //============================================================
  // Next state
  //============================================================
  always_comb
  begin
    st_d = st_q;
    // Read data and error are caught in setup so the access phase needs no wait
    if (setup_ph)
    begin
      st_d.err   = !mapped;
      st_d.rdata = (mapped && !PWRITE) ? rd_val : 32'h0000_0000;
    end
    if (access_ph && PWRITE && !st_q.err)
    begin
      if (PADDR == OFS_DUTY)
      begin
        st_d.duty = clamp_duty(wr_duty);
      end
      if (PADDR == OFS_FREQ)
      begin
        st_d.freq = clamp_freq(wr_freq);
      end
    end
    st_d.gate = ext_s && (sel_s || gen.out);
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= '{freq: FREQ_RST, duty: DUTY_RST, rdata: 32'h0000_0000, err: 1'b0, gate: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  //============================================================
  // Outputs
  //============================================================
  assign PREADY              = 1'b1;
  assign PSLVERR             = access_ph && st_q.err;
  assign PRDATA              = st_q.rdata;
  // One flop for both, so switching and series switch never skew
  assign SWITCH_ENABLE       = st_q.gate;
  assign PMOS_GATE_DRIVE_OUT = st_q.gate;

  //============================================================
  // Checks
  //============================================================
  logic [1:0] rst_age_q;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_age_q <= 2'h0;
    end
    else if (rst_age_q != 2'h2)
    begin
      rst_age_q <= rst_age_q + 2'h1;
    end
  end

  default clocking top_cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  gate_on_a : assert property (
    ext_s && sel_s |=> PMOS_GATE_DRIVE_OUT && SWITCH_ENABLE)
    else $error("gate not on while input high and select high");

  gate_off_a : assert property (
    !ext_s |=> !PMOS_GATE_DRIVE_OUT && !SWITCH_ENABLE)
    else $error("gate not off while input low");

  pin_latency_a : assert property (
    (sel_s && EXT_DIM_IN) [*4] |-> PMOS_GATE_DRIVE_OUT)
    else $error("gate drive lags the input by more than three cycles");

  follow_edge_a : assert property (
    sel_s && $past(sel_s) && $changed(ext_s) |=> $changed(PMOS_GATE_DRIVE_OUT))
    else $error("gate drive missed an input edge");

  duty_copy_a : assert property (
    $past(sel_s) |-> PMOS_GATE_DRIVE_OUT == $past(ext_s))
    else $error("gate drive duty differs from input duty");

  gen_idle_a : assert property (
    sel_s ##1 sel_s |-> !gen.out && gen.per == '0)
    else $error("generator active while select high");

  int_gate_a : assert property (
    !sel_s |=> PMOS_GATE_DRIVE_OUT == $past(ext_s && gen.out))
    else $error("generator output not gating the drive");

  and_gate_a : assert property (
    PMOS_GATE_DRIVE_OUT |-> $past(ext_s) && ($past(sel_s) || $past(gen.out)))
    else $error("gate high without both enables");

  freq_range_a : assert property (
    st_q.freq >= FREQ_K_MIN && st_q.freq <= FREQ_K_MAX)
    else $error("frequency setting outside range");

  duty_range_a : assert property (
    st_q.duty <= DUTY_K_MAX)
    else $error("duty setting above full scale");

  select_low_a : assert property (
    rst_age_q != 2'h2 |-> !sel_s && gen_en)
    else $error("select not low after reset");

  freq_write_a : assert property (
    access_ph && PWRITE && PADDR == OFS_FREQ && PSTRB[0] && !st_q.err && PWDATA[31:FREQ_W] == '0 &&
      PWDATA[FREQ_W-1:0] >= FREQ_K_MIN && PWDATA[FREQ_W-1:0] <= FREQ_K_MAX
      |=> st_q.freq == $past(PWDATA[FREQ_W-1:0]))
    else $error("frequency write not taken");

  bad_addr_a : assert property (
    setup_ph && !mapped ##1 access_ph |-> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not flagged");

endmodule

`default_nettype wire

// File: logic/ldp_pwm_gen.sv
`default_nettype none

module ldp_pwm_gen
  import ldp_pkg::*;
#(
  parameter int unsigned P_CYC_PER_KOHM = CYC_PER_KOHM
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Enable and settings
  input  wire logic        en,
  input  wire ldp_cfg_type cfg,
  // Generator output
  output var  ldp_gen_type gen
);

  localparam logic [PER_W-1:0] CYC_K = PER_W'(P_CYC_PER_KOHM);

  typedef struct packed {
    logic [PER_W-1:0] cnt;
    logic [PER_W-1:0] per;
    logic [PD_W-1:0]  pd;
    logic             out;
  } ldp_gen_state_type;

  ldp_gen_state_type st_q;
  ldp_gen_state_type st_d;
  logic              wrap;

  //==========================================================
  // Period counter
  //==========================================================
  // Settings are taken only at a period boundary, so a write never chops a pulse
  assign wrap = ({1'b0, st_q.cnt} + 22'h00_0001) >= {1'b0, st_q.per};

  always_comb
  begin
    st_d = st_q;
    if (!en)
    begin
      st_d = '0;
    end
    else
    begin
      if (wrap)
      begin
        st_d.cnt = '0;
        st_d.per = PER_W'(cfg.freq * CYC_K);
        st_d.pd  = PD_W'(st_d.per) * PD_W'(cfg.duty);
      end
      else
      begin
        st_d.cnt = st_q.cnt + 21'h00_0001;
      end
      st_d.out = (PD_W'(st_d.cnt) * PD_W'(DUTY_SCALE)) < st_d.pd;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign gen.out = st_q.out;
  assign gen.per = st_q.per;

  //==========================================================
  // Checks
  //==========================================================
  logic [PER_W-1:0] hi_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_q <= '0;
    end
    else if (st_q.cnt == '0)
    begin
      hi_q <= PER_W'(st_q.out);
    end
    else
    begin
      hi_q <= hi_q + PER_W'(st_q.out);
    end
  end

  default clocking gen_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  high_time_a : assert property (
    en && $past(en) && st_q.cnt == '0 && $past(st_q.cnt) != '0 |->
      PD_W'(hi_q) == ($past(st_q.pd) + PD_W'(DUTY_SCALE) - 33'h0_0000_0001) / PD_W'(DUTY_SCALE))
    else $error("high time does not match duty setting");

  period_len_a : assert property (
    en && $past(en) && st_q.cnt == '0 && $past(st_q.cnt) != '0 |->
      $past(st_q.cnt) == $past(st_q.per) - 21'h00_0001)
    else $error("period length does not match latched period");

  // A wrap seen while reset still holds the state latches nothing
  freq_calc_a : assert property (
    en && $past(en) && $past(wrap) && $past(rst_n) |-> st_q.per == PER_W'($past(cfg.freq) * CYC_K))
    else $error("period not derived from frequency setting");

endmodule

`default_nettype wire

// File: logic/ldp_sync.sv
`default_nettype none

module ldp_sync
  import ldp_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic d,
  output var  logic q
);

  typedef struct packed {
    logic meta;
    logic stable;
  } ldp_sync_state_type;

  ldp_sync_state_type st_q;
  ldp_sync_state_type st_d;

  always_comb
  begin
    st_d.meta   = d;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '{meta: RST_VAL, stable: RST_VAL};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign q = st_q.stable;

endmodule

`default_nettype wire

// File: testbench/ldp_dim_source.sv
`default_nettype none

module ldp_dim_source
(
  // Clock
  input  wire logic        clk,
  // Source setup
  input  wire logic        pwm_on,
  input  wire logic        level,
  input  wire logic [15:0] hi_cyc,
  input  wire logic [15:0] lo_cyc,
  // Dimming pin
  output var  logic        pin,
  // Series switch and current meter
  input  wire logic        gate,
  input  wire logic        clr,
  output var  logic [15:0] on_cyc
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] cnt_q;

  initial
  begin
    pin    = 1'b0;
    cnt_q  = 16'h0000;
    on_cyc = 16'h0000;
  end

  //==========================================================
  // Pin waveform
  //==========================================================
  // Period of many cycles, slow next to converter switching
  always @(posedge clk)
  begin
    if (!pwm_on)
    begin
      cnt_q <= 16'h0000;
      pin   <= level;
    end
    else
    begin
      cnt_q <= (cnt_q + 16'h0001 >= hi_cyc + lo_cyc) ? 16'h0000 : cnt_q + 16'h0001;
      pin   <= (cnt_q < hi_cyc);
    end
  end

  //==========================================================
  // Series switch
  //==========================================================
  // Conducting cycles stand in for average current
  always @(posedge clk)
  begin
    on_cyc <= clr ? 16'h0000 : on_cyc + {15'h0000, gate};
  end

endmodule

`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ldp_pkg::*;

  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] exp;
    logic        err;
  } ldp_row_type;

  localparam int unsigned CYC = 4;
  localparam ldp_row_type ROWS [13] = '{
    '{1'b0, OFS_DUTY,   32'h0000_0000, 4'hF, 32'h0000_0708, 1'b0},
    '{1'b0, OFS_FREQ,   32'h0000_0000, 4'hF, 32'h0000_0064, 1'b0},
    '{1'b1, OFS_DUTY,   32'h0000_0FFF, 4'hF, 32'h0000_0000, 1'b0},
    '{1'b0, OFS_DUTY,   32'h0000_0000, 4'hF, 32'h0000_0E10, 1'b0},
    '{1'b1, OFS_FREQ,   32'h0000_0005, 4'hF, 32'h0000_0000, 1'b0},
    '{1'b0, OFS_FREQ,   32'h0000_0000, 4'hF, 32'h0000_000A, 1'b0},
    '{1'b1, OFS_FREQ,   32'h0000_00FF, 4'hF, 32'h0000_0000, 1'b0},
    '{1'b0, OFS_FREQ,   32'h0000_0000, 4'hF, 32'h0000_00C8, 1'b0},
    '{1'b1, OFS_FREQ,   32'h0000_0032, 4'h0, 32'h0000_0000, 1'b0},
    '{1'b0, OFS_FREQ,   32'h0000_0000, 4'hF, 32'h0000_00C8, 1'b0},
    '{1'b1, 8'h10,      32'h0000_0001, 4'hF, 32'h0000_0000, 1'b1},
    '{1'b0, 8'h10,      32'h0000_0000, 4'hF, 32'h0000_0000, 1'b1},
    '{1'b0, OFS_PERIOD, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'b0}};
  // Both ends of the settable frequency span
  localparam int GEN [4][2] = '{'{10, 1800}, '{10, 180}, '{10, 3420}, '{200, 1800}};

  logic        mclk    = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'h0;
  logic        sel_n   = 1'b0;
  logic        pwm_on  = 1'b0;
  logic        level   = 1'b1;
  logic [15:0] hi      = 16'h0001;
  logic [15:0] lo      = 16'h0001;
  logic        clr     = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_pin;
  logic        sw_en;
  logic        gate_out;
  logic [15:0] on_cyc;
  int          fail_count  = 0;
  int          check_count = 0;

  always #2.5 mclk = ~mclk;

  ldp_dimming_top #(.P_CYC_PER_KOHM(CYC)) i_ldp_dimming_top (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_DIM_IN(ext_pin), .INT_DIM_SELECT_N(sel_n), .SWITCH_ENABLE(sw_en), .PMOS_GATE_DRIVE_OUT(gate_out));

  ldp_dim_source i_ldp_dim_source (
    .clk(mclk), .pwm_on(pwm_on), .level(level), .hi_cyc(hi), .lo_cyc(lo), .pin(ext_pin),
    .gate(gate_out), .clr(clr), .on_cyc(on_cyc));

  //==========================================================
  // Tasks
  //==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
    begin
      fail_count++;
      stop_test();
    end
  endtask

  // Level to output takes four edges, one at the source flop and three to the gate, plus one of sampling slack
  task automatic wait_gate(input logic exp);
    int n;
    for (n = 0; n < 5; n++)
    begin
      @(posedge mclk);
      if (gate_out === exp)
        break;
    end
    if (n == 5)
    begin
      fail_count++;
      stop_test();
    end
    chk(32'(sw_en), 32'(exp));
  endtask

  // Counts conducting samples of the series switch over a window of n cycles
  task automatic measure(input int n, input logic [15:0] exp);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (n + 1) @(posedge mclk);
    chk(32'(on_cyc), 32'(exp));
  endtask

  //==========================================================
  // Main sequence
  //==========================================================
  initial
  begin
    int          i;
    int          per;
    int          hi_exp;
    logic [31:0] rd;
    logic        er;
    repeat (5) @(posedge mclk);
    chk(32'({sw_en, gate_out}), 32'h0000_0000);
    rst_n <= 1'b1;
    // Select held low, as the pull-down leaves it
    repeat (1000) @(posedge mclk);
    measure(800, 16'h0190);
    apb(1'b0, OFS_STATUS, 32'h0000_0000, 4'hF, rd, er);
    chk(32'(rd[ST_GEN_ON]), 32'h0000_0001);
    sel_n <= 1'b1;
    level <= 1'b0;
    wait_gate(1'b0);
    for (i = 0; i < 13; i++)
    begin
      apb(ROWS[i].wr, ROWS[i].a, ROWS[i].d, ROWS[i].s, rd, er);
      if (!ROWS[i].wr)
        chk(rd, ROWS[i].exp);
      chk(32'(er), 32'(ROWS[i].err));
    end
    level <= 1'b1;
    wait_gate(1'b1);
    measure(400, 16'h0190);
    level <= 1'b0;
    wait_gate(1'b0);
    // Generator is off, so only the pin dims
    hi     <= 16'h0001;
    lo     <= 16'h0003;
    pwm_on <= 1'b1;
    repeat (20) @(posedge mclk);
    measure(400, 16'h0064);
    hi <= 16'h001E;
    lo <= 16'h0046;
    repeat (200) @(posedge mclk);
    measure(1000, 16'h012C);
    pwm_on <= 1'b0;
    level  <= 1'b1;
    sel_n  <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      per    = GEN[i][0] * CYC;
      hi_exp = (per * GEN[i][1] + 3599) / 3600;
      apb(1'b1, OFS_FREQ, 32'(GEN[i][0]), 4'hF, rd, er);
      apb(1'b1, OFS_DUTY, 32'(GEN[i][1]), 4'hF, rd, er);
      // Settings take hold only at a period end
      repeat (1700) @(posedge mclk);
      apb(1'b0, OFS_PERIOD, 32'h0000_0000, 4'hF, rd, er);
      chk(rd, 32'(per));
      measure(4 * per, 16'(4 * hi_exp));
    end
    level <= 1'b0;
    repeat (8) @(posedge mclk);
    measure(200, 16'h0000);
    // Gate high going into reset, so the clear is visible
    level <= 1'b1;
    sel_n <= 1'b1;
    wait_gate(1'b1);
    rst_n <= 1'b0;
    @(posedge mclk);
    chk(32'({sw_en, gate_out}), 32'h0000_0000);
    rst_n <= 1'b1;
    apb(1'b0, OFS_DUTY, 32'h0000_0000, 4'hF, rd, er);
    chk(rd, 32'h0000_0708);
    apb(1'b0, OFS_FREQ, 32'h0000_0000, 4'hF, rd, er);
    chk(rd, 32'h0000_0064);
    stop_test();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    stop_test();
  end

endmodule

`default_nettype wire
